// file: temp_window_pkg.sv
// Purpose: constants, register map and state types of the temperature
//          window alert block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   threshold code is 7-bit two's complement, 2 degC per step.
`default_nettype none

package temp_window_pkg;

  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_COMMAND    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h10;

  // command byte layout
  localparam int CMD_MASK_BIT = 7;
  localparam int THR_W        = 7;

  // temperature scale
  localparam int THR_STEP_DEG = 2;
  localparam int TRIP_RST_DEG = 100;
  localparam int WINDOW_DEG   = 8;
  localparam logic [THR_W-1:0] THR_RST = 7'(TRIP_RST_DEG / THR_STEP_DEG);

  // status byte positions
  localparam int STS_OVER_BIT  = 7;
  localparam int STS_UNDER_BIT = 6;

  // interrupt event bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_OVER_BIT  = 0;
  localparam int IRQ_UNDER_BIT = 1;
  localparam int IRQ_ALERT_BIT = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]        temp_s1;
    logic [7:0]        temp_s2;
    logic [7:0]        temp_s3;
    logic [7:0]        temp_ok;
    logic [THR_W-1:0]  thr;
    logic              mask;
    logic              over;
    logic              under;
    logic              latch;
    logic              alert_n;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } state_type;

  localparam state_type STATE_RST = '{
    thr:     THR_RST,
    mask:    1'b1,
    alert_n: 1'b1,
    default: '0
  };

endpackage

`default_nettype wire

// file: temp_window_alert.sv
// Purpose: threshold compare, window edge, alert latch and status flags of a
//          temperature monitor, reached over AXI4-Lite.
// Assumes: temp_i is a slow signed degC code from another domain.
// Notes:   command register takes the threshold/mask byte in lane 0; status
//          register read clears flags and latch.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`default_nettype none

module temp_window_alert (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  temp_i,
  output logic             alert_n_o,
  output logic             irq_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  temp_window_pkg::state_type st_q;
  temp_window_pkg::state_type st_d;

  logic                    aw_hs;
  logic                    w_hs;
  logic                    ar_hs;
  logic                    commit;
  logic [7:0]              wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic                    cmd_wr;
  logic                    stat_rd;
  logic                    clr;
  logic [6:0]              thr_eff;
  logic                    mask_eff;
  logic signed [8:0]       temp_x;
  logic signed [8:0]       thr_x;
  logic signed [8:0]       edge_x;
  logic                    over_cond;
  logic                    under_cond;
  logic [7:0]              status_byte;
  logic [2:0]              irq_ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rdata   = st_q.rdata;
  assign alert_n_o     = st_q.alert_n;
  assign irq_o         = st_q.irq;

  assign aw_hs  = s_axi_awvalid && s_axi_awready;
  assign w_hs   = s_axi_wvalid && s_axi_wready;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  // address and data may arrive in either order; act when both are held
  assign commit = (st_q.aw_got || aw_hs) && (st_q.w_got || w_hs);
  assign wr_addr = st_q.aw_got ? st_q.awaddr : s_axi_awaddr;
  assign wr_data = st_q.w_got ? st_q.wdata : s_axi_wdata;
  assign wr_strb = st_q.w_got ? st_q.wstrb : s_axi_wstrb;

  assign cmd_wr  = commit && wr_strb[0]
                   && hit(wr_addr, temp_window_pkg::OFF_COMMAND);
  assign stat_rd = ar_hs && hit(s_axi_araddr, temp_window_pkg::OFF_STATUS);
  assign clr     = cmd_wr || stat_rd;

  // a new threshold is compared from the write cycle on, so the old one
  // cannot re-latch the alert the host has just released
  assign thr_eff  = cmd_wr ? wr_data[6:0] : st_q.thr;
  assign mask_eff = cmd_wr ? wr_data[temp_window_pkg::CMD_MASK_BIT]
                           : st_q.mask;

  assign temp_x = $signed({st_q.temp_ok[7], st_q.temp_ok});
  assign thr_x  = $signed({thr_eff[6], thr_eff, 1'b0});
  assign edge_x = thr_x - $signed(9'(temp_window_pkg::WINDOW_DEG));

  assign over_cond  = temp_x > thr_x;
  assign under_cond = !mask_eff && (temp_x < edge_x);

  always_comb begin
    status_byte = 8'h00;
    status_byte[temp_window_pkg::STS_OVER_BIT]  = st_q.over;
    status_byte[temp_window_pkg::STS_UNDER_BIT] = st_q.under;
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[temp_window_pkg::IRQ_OVER_BIT]  = over_cond && !st_q.over;
    irq_ev[temp_window_pkg::IRQ_UNDER_BIT] = under_cond && !st_q.under;
    irq_ev[temp_window_pkg::IRQ_ALERT_BIT] = (over_cond || under_cond)
                                             && !st_q.latch;
  end

  always_comb begin
    st_d = st_q;
    st_d.temp_s1 = temp_i;
    st_d.temp_s2 = st_q.temp_s1;
    // the code is a multi-bit word from another domain: take it only once
    // two settled samples agree, so a half-changed code never trips a flag
    st_d.temp_s3 = st_q.temp_s2;
    if (st_q.temp_s2 == st_q.temp_s3) begin
      st_d.temp_ok = st_q.temp_s2;
    end

    // write channel
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (commit) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = temp_window_pkg::RESP_OKAY;
      if (hit(wr_addr, temp_window_pkg::OFF_COMMAND)) begin
        if (wr_strb[0]) begin
          st_d.thr  = thr_eff;
          st_d.mask = mask_eff;
        end
      end else if (hit(wr_addr, temp_window_pkg::OFF_IRQ_CLEAR)) begin
        if (wr_strb[0]) begin
          st_d.irq_sts = st_q.irq_sts & ~wr_data[2:0];
        end
      end else if (hit(wr_addr, temp_window_pkg::OFF_IRQ_ENABLE)) begin
        if (wr_strb[0]) begin
          st_d.irq_en = wr_data[2:0];
        end
      end else if (!hit(wr_addr, temp_window_pkg::OFF_STATUS)
                   && !hit(wr_addr, temp_window_pkg::OFF_IRQ_STATUS)) begin
        st_d.bresp = temp_window_pkg::RESP_SLVERR;
      end
    end else begin
      if (aw_hs) begin
        st_d.aw_got = 1'b1;
        st_d.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
        st_d.w_got = 1'b1;
        st_d.wdata = s_axi_wdata;
        st_d.wstrb = s_axi_wstrb;
      end
    end

    // read channel
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = temp_window_pkg::RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      if (hit(s_axi_araddr, temp_window_pkg::OFF_COMMAND)) begin
        st_d.rdata[7:0] = {st_q.mask, st_q.thr};
      end else if (hit(s_axi_araddr, temp_window_pkg::OFF_STATUS)) begin
        st_d.rdata[7:0] = status_byte;
      end else if (hit(s_axi_araddr, temp_window_pkg::OFF_IRQ_STATUS)) begin
        st_d.rdata[2:0] = st_q.irq_sts;
      end else if (hit(s_axi_araddr, temp_window_pkg::OFF_IRQ_ENABLE)) begin
        st_d.rdata[2:0] = st_q.irq_en;
      end else if (!hit(s_axi_araddr, temp_window_pkg::OFF_IRQ_CLEAR)) begin
        st_d.rresp = temp_window_pkg::RESP_SLVERR;
      end
    end

    // flags and latch: a present condition wins over a clear
    st_d.over  = (st_q.over && !clr) || over_cond;
    st_d.under = (st_q.under && !clr) || under_cond;
    st_d.latch = (st_q.latch && !clr) || over_cond || under_cond;
    st_d.alert_n = !st_d.latch;

    // an event in the clearing cycle survives the write-1-clear
    st_d.irq_sts = st_d.irq_sts | irq_ev;
    st_d.irq     = |(st_d.irq_sts & st_d.irq_en);
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_q <= temp_window_pkg::STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // checks
  // properties sample at the rising edge and rest while reset is low
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence seq_cmd_write;
    cmd_wr;
  endsequence

  sequence seq_status_read;
    stat_rd;
  endsequence

  sequence seq_read_answer;
    ##1 st_q.rvalid;
  endsequence

  sequence seq_write_answer;
    ##1 s_axi_bvalid;
  endsequence

  property p_reset_thr;
    $rose(resetn_i) |-> st_q.thr == temp_window_pkg::THR_RST;
  endproperty

  property p_reset_mask;
    $rose(resetn_i) |-> st_q.mask && st_q.alert_n && !st_q.under;
  endproperty

  property p_cmd_loads;
    seq_cmd_write
      |=> {st_q.mask, st_q.thr} == $past(wr_data[7:0]) && s_axi_bvalid;
  endproperty

  chk_reset_thr_load: assert property (p_reset_thr)
    else $error("threshold not at reset code after reset");

  chk_cmd_byte_load: assert property (p_cmd_loads)
    else $error("command byte not taken as threshold and mask");

  chk_reset_under_mask: assert property (p_reset_mask)
    else $error("lower window not masked after reset");

  chk_over_sets_latch: assert property (
    over_cond |=> st_q.over && st_q.latch && !alert_n_o)
    else $error("over condition did not set flag and alert");

  chk_read_reasserts: assert property (
    (seq_status_read ##0 over_cond) |=> st_q.latch && st_q.over
      && !alert_n_o)
    else $error("alert not re-asserted after status read");

  chk_mask_bit_write: assert property (
    seq_cmd_write |=> st_q.mask == $past(wr_data[7]))
    else $error("mask bit not taken from command byte");

  chk_write_clears: assert property (
    (seq_cmd_write ##0 !over_cond ##0 !under_cond)
      |=> !st_q.over && !st_q.under && alert_n_o)
    else $error("threshold write did not clear flags and alert");

  chk_under_sets_latch: assert property (
    (!st_q.mask && temp_x < thr_x - 9'sd8 && !cmd_wr)
      |=> st_q.under && !alert_n_o)
    else $error("under condition did not set flag and alert");

  chk_masked_no_under: assert property (
    (st_q.mask && !cmd_wr && !over_cond && !st_q.over && !st_q.latch)
      |=> !st_q.under && alert_n_o)
    else $error("masked lower window raised alert");

  chk_status_over_bit: assert property (
    (seq_status_read ##0 st_q.over) |-> seq_read_answer
      ##0 st_q.rdata[7])
    else $error("over flag not in status bit 7");

  chk_status_under_bit: assert property (
    (seq_status_read ##0 st_q.under) |-> seq_read_answer
      ##0 st_q.rdata[6])
    else $error("under flag not in status bit 6");

  chk_set_after_clear: assert property (
    (seq_status_read ##1 (over_cond && !cmd_wr)) |=> !alert_n_o)
    else $error("condition after clear was lost");

  chk_irq_follows: assert property (
    (st_q.irq_sts != 3'h0 && (st_q.irq_sts & st_q.irq_en) != 3'h0
      && !commit) |=> irq_o)
    else $error("enabled interrupt status did not raise irq");

  chk_window_edge: assert property (
    (!st_q.mask && !cmd_wr && !st_q.under && temp_x >= thr_x - 9'sd8)
      |=> !st_q.under)
    else $error("under flag set at or above the window edge");

  chk_read_clears: assert property (
    (seq_status_read ##0 !over_cond ##0 !under_cond)
      |=> !st_q.over && !st_q.under && alert_n_o)
    else $error("status read did not clear flags and alert");

  chk_latch_holds: assert property (
    (st_q.latch && !clr) |=> !alert_n_o)
    else $error("alert released without a clear");

  chk_alert_quiet: assert property (
    (alert_n_o && !over_cond && !under_cond) |=> alert_n_o)
    else $error("alert raised with no condition present");

  chk_cfg_stable: assert property (
    !cmd_wr |=> $stable({st_q.mask, st_q.thr}))
    else $error("threshold or mask changed without a command write");

  chk_irq_sticky: assert property (
    !commit |=> (st_q.irq_sts & $past(st_q.irq_sts))
      == $past(st_q.irq_sts))
    else $error("interrupt status bit lost without a clear write");

  // bus answers come one cycle after acceptance
  chk_write_answer: assert property (
    commit |-> seq_write_answer)
    else $error("write response did not follow the accepted write");

  chk_read_answer: assert property (
    ar_hs |-> seq_read_answer)
    else $error("read data did not follow the accepted address");

  chk_unmapped_read: assert property (
    (ar_hs && s_axi_araddr[7:2] > 6'h04) |=> s_axi_rresp
      == temp_window_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

endmodule

`default_nettype wire

// file: axil_host_model.sv
// Purpose: firmware-side host model reaching the block over AXI4-Lite.
// Assumes: ready and answers are sampled at the rising edge, pre-update.
// Notes:   released payload shows the inverse of its last value.
`default_nettype none

module axil_host_model (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic b;
    b = 1'b0;
    r = 2'h0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!b) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      b = bvalid_i;
      r = bresp_i;
    end
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic v;
    v = 1'b0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!v) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      v = rvalid_i;
      d = rdata_i;
      r = rresp_i;
    end
    rready_o <= 1'b0;
  endtask

  // bit-by-bit threshold search, under events kept masked
  task automatic sar(output int deg);
    int hi, lo, t;
    logic [31:0] s;
    logic [1:0] r;
    hi = 63;
    lo = -64;
    t = 0;
    while (hi - lo > 0) begin
      t = (hi + lo) / 2;
      wr(temp_window_pkg::OFF_COMMAND, 32'({1'b1, 7'(t)}), r);
      repeat (6) @(posedge clk_i);
      rd(temp_window_pkg::OFF_STATUS, s, r);
      if ((s & 32'h0000_0080) != 32'h0) begin
        if (lo == t) break;
        lo = t;
      end else begin
        if (hi == t) break;
        hi = t;
      end
    end
    deg = t * 2;
  endtask
endmodule

`default_nettype wire

// file: tb_temp_window_alert.sv
// Purpose: self-checking bench of the temperature window alert block.
// Assumes: host model owns the bus; bench drives temperature and reset.
// Notes:   alert_n and irq are judged at the falling edge; bus answers at the rising edge.
`default_nettype none

module tb_temp_window_alert;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  temp = 8'h00;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, alert_n, irq;
  int          err_total = 0;
  int          total_checks = 0;

  always #2 clk = ~clk;

  temp_window_alert temp_window_alert_i (
    .core_clk_i(clk), .resetn_i(rst_n), .temp_i(temp),
    .alert_n_o(alert_n), .irq_o(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  axil_host_model axil_host_model_i (
    .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axil_host_model_i.wr(a, d, r);
    chk("bresp", 32'(temp_window_pkg::RESP_OKAY), 32'(r));
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axil_host_model_i.rd(a, d, r);
    chk(n, e, d);
    chk("rresp", 32'(temp_window_pkg::RESP_OKAY), 32'(r));
  endtask

  task automatic put(input logic [7:0] t);
    @(posedge clk);
    temp <= t;
  endtask

  // hold: let eight cycles pass unchecked first; in both cases then wait up to eight for the level
  task automatic alert_is(input logic e, input logic hold, input string n);
    int i;
    if (hold) repeat (8) @(negedge clk);
    for (i = 0; i < 8 && alert_n !== e; i++) @(negedge clk);
    chk(n, 32'(e), 32'(alert_n));
  endtask

  task automatic irq_is(input logic e, input string n);
    repeat (3) @(negedge clk);
    chk(n, 32'(e), 32'(irq));
  endtask

  task automatic t_reset();
    rdc("command", temp_window_pkg::OFF_COMMAND, 32'({1'b1, 7'd50}));
    put(8'hEC);
    alert_is(1'b1, 1'b1, "masked under");
    rdc("status", temp_window_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic t_over();
    wr(temp_window_pkg::OFF_IRQ_ENABLE, 32'h7);
    put(8'd100);
    alert_is(1'b1, 1'b1, "at threshold");
    put(8'd101);
    alert_is(1'b0, 1'b0, "over alert");
    irq_is(1'b1, "irq over");
    rdc("status over", temp_window_pkg::OFF_STATUS, 32'h80);
    alert_is(1'b0, 1'b1, "re-assert");
    rdc("status again", temp_window_pkg::OFF_STATUS, 32'h80);
  endtask

  task automatic t_window();
    wr(temp_window_pkg::OFF_COMMAND, 32'({1'b0, 7'd52}));
    alert_is(1'b1, 1'b1, "released");
    rdc("status clr", temp_window_pkg::OFF_STATUS, 32'h0);
    put(8'd96);
    alert_is(1'b1, 1'b1, "at edge");
    put(8'd95);
    alert_is(1'b0, 1'b0, "under alert");
    put(8'd100);
    alert_is(1'b0, 1'b1, "under latched");
    rdc("status under", temp_window_pkg::OFF_STATUS, 32'h40);
    alert_is(1'b1, 1'b0, "read release");
    rdc("status read clr", temp_window_pkg::OFF_STATUS, 32'h0);
    put(8'd95);
    alert_is(1'b0, 1'b0, "under again");
    wr(temp_window_pkg::OFF_COMMAND, 32'({1'b1, 7'd52}));
    alert_is(1'b1, 1'b1, "remasked");
    rdc("status mask", temp_window_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic t_irq();
    rdc("irq sts", temp_window_pkg::OFF_IRQ_STATUS, 32'h7);
    wr(temp_window_pkg::OFF_IRQ_CLEAR, 32'h7);
    irq_is(1'b0, "irq cleared");
    rdc("irq sts clr", temp_window_pkg::OFF_IRQ_STATUS, 32'h0);
    wr(temp_window_pkg::OFF_IRQ_ENABLE, 32'h0);
    put(8'd120);
    alert_is(1'b0, 1'b0, "hot alert");
    irq_is(1'b0, "irq masked");
    rdc("irq en", temp_window_pkg::OFF_IRQ_ENABLE, 32'h0);
    wr(temp_window_pkg::OFF_IRQ_ENABLE, 32'h1);
    irq_is(1'b1, "irq enabled");
    wr(temp_window_pkg::OFF_IRQ_CLEAR, 32'h1);
    irq_is(1'b0, "irq w1c");
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    axil_host_model_i.rd(8'h20, d, r);
    chk("unmapped resp", 32'(temp_window_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    axil_host_model_i.wr(8'h20, 32'h0000_0001, r);
    chk("unmapped wr resp", 32'(temp_window_pkg::RESP_SLVERR), 32'(r));
    rdc("clear reads 0", temp_window_pkg::OFF_IRQ_CLEAR, 32'h0);
    wr(temp_window_pkg::OFF_STATUS, 32'hFF);
    rdc("status ro", temp_window_pkg::OFF_STATUS, 32'h80);
  endtask

  task automatic t_sar();
    int deg;
    put(8'd37);
    axil_host_model_i.sar(deg);
    chk("sar degC", 32'(((37 - 1) / 2) * 2), 32'(deg));
  endtask

  task automatic t_rerun();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    alert_is(1'b1, 1'b0, "alert reset");
    irq_is(1'b0, "irq reset");
    rdc("cmd reset", temp_window_pkg::OFF_COMMAND, 32'h0000_00B2);
    rdc("status reset", temp_window_pkg::OFF_STATUS, 32'h0);
    rdc("irq en reset", temp_window_pkg::OFF_IRQ_ENABLE, 32'h0);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_over();
    t_window();
    t_irq();
    t_bus();
    t_sar();
    t_rerun();
    print_verdict();
  end
endmodule

`default_nettype wire
